// [design/rtar_remap.sv]
// remote target alias remapper for all receive ports of the hub
// assumes txn and ack strobes come from logic on ref_clk, one transaction at a time
`timescale 1ns/1ps

module rtar_remap
   import rtar_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]      reg_rdata,
   input  wire logic       txn_valid,
   input  wire logic [6:0] txn_addr,
   input  wire logic       txn_read,
   input  wire logic       ser_ack_valid,
   input  wire logic       ser_ack,
   output logic            fwd_valid,
   output logic [1:0]      fwd_port,
   output logic [6:0]      fwd_addr,
   output logic            fwd_read,
   output logic            host_ack_valid,
   output logic            host_ack
);
   import rtar_pkg::*;

   logic [1:0]                 port_sel_reg;
   rtar_slot_addr_t            phys_w   [RTAR_NUM_PORTS];
   rtar_slot_addr_t            alias_w  [RTAR_NUM_PORTS];
   logic [RTAR_NUM_SLOTS-1:0]  auto_w   [RTAR_NUM_PORTS];
   logic [7:0]                 rdata_w  [RTAR_NUM_PORTS];
   logic                       match_found;
   logic [1:0]                 match_port;
   logic [6:0]                 match_phys;
   logic                       match_auto;
   logic                       auto_pend_reg;
   logic                       auto_pend_next;

   ////////////////////////////////////////////////////////////////////////////////////////
   // port select register
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         port_sel_reg <= RTAR_RST_PORT_SEL;
      end else if (reg_wr && reg_addr == RTAR_OFS_PORT_SEL) begin
         port_sel_reg <= reg_wdata[1:0];
      end
   end

   // one register copy per receive port, written only when selected
   for (genvar p = 0; p < RTAR_NUM_PORTS; p++) begin : g_port
      rtar_port_regs u_regs (
         .ref_clk           (ref_clk),
         .resetn            (resetn),
         .wr_en             (reg_wr && port_sel_reg == 2'(p)),
         .addr              (reg_addr),
         .wdata             (reg_wdata),
         .target_phys_addr  (phys_w[p]),
         .target_alias_addr (alias_w[p]),
         .auto_ack          (auto_w[p]),
         .rdata             (rdata_w[p])
      );
   end

   // registered readback from the selected port
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == RTAR_OFS_PORT_SEL) begin
            reg_rdata <= {6'h00, port_sel_reg};
         end else begin
            reg_rdata <= rdata_w[port_sel_reg];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // alias decoder, lowest port then lowest slot wins
   always_comb begin
      match_found = 1'b0;
      match_port  = 2'h0;
      match_phys  = 7'h00;
      match_auto  = 1'b0;
      for (int p = 0; p < RTAR_NUM_PORTS; p++) begin
         for (int s = 0; s < RTAR_NUM_SLOTS; s++) begin
            if (!match_found && alias_w[p][s] != RTAR_ALIAS_OFF
                && txn_addr == alias_w[p][s]) begin
               match_found = 1'b1;
               match_port  = 2'(p);
               match_phys  = phys_w[p][s];
               match_auto  = auto_w[p][s];
            end
         end
      end
   end

   // forward the remapped address toward the serializer
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         fwd_valid <= 1'b0;
         fwd_port  <= 2'h0;
         fwd_addr  <= 7'h00;
         fwd_read  <= 1'b0;
      end else begin
         fwd_valid <= txn_valid && match_found;
         if (txn_valid && match_found) begin
            fwd_port <= match_port;
            fwd_addr <= match_phys;
            fwd_read <= txn_read;
         end
      end
   end

   // auto-acknowledged write waiting for the serializer reply it will ignore
   always_comb begin
      auto_pend_next = auto_pend_reg;
      if (ser_ack_valid) begin
         auto_pend_next = 1'b0;
      end
      if (txn_valid && match_found && match_auto && !txn_read) begin
         auto_pend_next = 1'b1;   // set wins over clear
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         auto_pend_reg <= 1'b0;
      end else begin
         auto_pend_reg <= auto_pend_next;
      end
   end

   // answer to the local controller: nack on miss, ack on auto write, else serializer
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         host_ack_valid <= 1'b0;
         host_ack       <= 1'b0;
      end else if (txn_valid && (!match_found || (match_auto && !txn_read))) begin
         host_ack_valid <= 1'b1;
         host_ack       <= match_found;
      end else if (ser_ack_valid && !auto_pend_reg) begin
         host_ack_valid <= 1'b1;
         host_ack       <= ser_ack;
      end else begin
         host_ack_valid <= 1'b0;
         host_ack       <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // checks
   property p_port_copy;
      @(posedge ref_clk) disable iff (!resetn)
      reg_wr && reg_addr == RTAR_OFS_PHYS[1]
      |=> phys_w[$past(port_sel_reg)][1] == $past(reg_wdata[7:1]);
   endproperty
   a_port_copy: assert property (p_port_copy)
      else $error("selected port copy not written");

   property p_rsvd_zero;
      @(posedge ref_clk) disable iff (!resetn)
      reg_rd && (reg_addr == RTAR_OFS_PHYS[1] || reg_addr == RTAR_OFS_PHYS[3])
      |=> reg_rdata[RTAR_RSVD_BIT] == 1'b0
          && reg_rdata[7:1] == (($past(reg_addr) == RTAR_OFS_PHYS[1])
                                ? phys_w[port_sel_reg][1] : phys_w[port_sel_reg][3]);
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero)
      else $error("physical address readback wrong");

   property p_remap_hi;
      @(posedge ref_clk) disable iff (!resetn)
      txn_valid && alias_w[0][2] != RTAR_ALIAS_OFF && txn_addr == alias_w[0][2]
      && txn_addr != alias_w[0][0] && txn_addr != alias_w[0][1]
      |=> fwd_valid && fwd_port == 2'h0 && fwd_addr == $past(phys_w[0][2]);
   endproperty
   a_remap_hi: assert property (p_remap_hi)
      else $error("slot six alias not remapped");

   property p_remap_zero;
      @(posedge ref_clk) disable iff (!resetn)
      txn_valid && alias_w[0][0] != RTAR_ALIAS_OFF && txn_addr == alias_w[0][0]
      |=> fwd_valid && fwd_port == 2'h0 && fwd_addr == $past(phys_w[0][0]);
   endproperty
   a_remap_zero: assert property (p_remap_zero)
      else $error("alias zero not redirected to physical zero");

   property p_disabled;
      @(posedge ref_clk) disable iff (!resetn)
      txn_valid && !match_found |=> !fwd_valid && host_ack_valid && !host_ack;
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("unmatched or disabled alias forwarded");

   property p_auto_ack;
      @(posedge ref_clk) disable iff (!resetn)
      txn_valid && match_found && match_auto && !txn_read
      |=> host_ack_valid && host_ack && !fwd_read;
   endproperty
   a_auto_ack: assert property (p_auto_ack)
      else $error("auto acknowledged write not acked");

   property p_reset_vals;
      @(posedge ref_clk)
      !resetn |=> alias_w[0][0] == 7'h00 && auto_w[0][0] == 1'b0
                  && phys_w[0][1] == 7'h00 && phys_w[0][2] == 7'h00;
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("reset values wrong");

endmodule

// [include/rtar_pkg.sv]
// constants and types for the remote target alias remapper
// assumes one register access port per hub, decoded to byte offsets
package rtar_pkg;

   // hub geometry
   localparam int RTAR_NUM_PORTS = 4;
   localparam int RTAR_NUM_SLOTS = 4;        // local slot 0..3 = remote slot 0, 5, 6, 7

   typedef logic [RTAR_NUM_SLOTS-1:0][6:0] rtar_slot_addr_t;
   typedef logic [RTAR_NUM_SLOTS-1:0][7:0] rtar_slot_ofs_t;

   ////////////////////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [7:0]      RTAR_OFS_PORT_SEL = 8'h4c;
   localparam rtar_slot_ofs_t  RTAR_OFS_PHYS     = {8'h64, 8'h63, 8'h62, 8'h5d};
   localparam rtar_slot_ofs_t  RTAR_OFS_ALIAS    = {8'h6c, 8'h6b, 8'h6a, 8'h65};

   // field positions
   localparam int RTAR_ADDR_MSB     = 7;
   localparam int RTAR_ADDR_LSB     = 1;
   localparam int RTAR_AUTO_ACK_BIT = 0;
   localparam int RTAR_RSVD_BIT     = 0;

   ////////////////////////////////////////////////////////////////////////////////////////
   // values after reset
   localparam rtar_slot_addr_t          RTAR_RST_PHYS     = {7'h00, 7'h00, 7'h00, 7'h00};
   localparam rtar_slot_addr_t          RTAR_RST_ALIAS    = {7'h00, 7'h00, 7'h00, 7'h00};
   localparam logic [RTAR_NUM_SLOTS-1:0] RTAR_RST_AUTO_ACK = 4'h0;
   localparam logic [1:0]               RTAR_RST_PORT_SEL = 2'h0;
   localparam logic [6:0]               RTAR_ALIAS_OFF    = 7'h00;   // alias value that disables

endpackage

// [design/rtar_port_regs.sv]
// one receive port's copy of the remote target physical and alias registers
// assumes the caller qualifies wr_en with the port select
`timescale 1ns/1ps

module rtar_port_regs
   import rtar_pkg::*;
(
   input  wire logic                           ref_clk,
   input  wire logic                           resetn,
   input  wire logic                           wr_en,
   input  wire logic [7:0]                     addr,
   input  wire logic [7:0]                     wdata,
   output rtar_pkg::rtar_slot_addr_t           target_phys_addr,
   output rtar_pkg::rtar_slot_addr_t           target_alias_addr,
   output logic [rtar_pkg::RTAR_NUM_SLOTS-1:0] auto_ack,
   output logic [7:0]                          rdata
);
   import rtar_pkg::*;

   rtar_slot_addr_t             phys_reg;
   rtar_slot_addr_t             alias_reg;
   logic [RTAR_NUM_SLOTS-1:0]   ack_reg;

   ////////////////////////////////////////////////////////////////////////////////////////
   // register writes, per slot decode
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         phys_reg  <= RTAR_RST_PHYS;
         alias_reg <= RTAR_RST_ALIAS;
         ack_reg   <= RTAR_RST_AUTO_ACK;
      end else if (wr_en) begin
         for (int s = 0; s < RTAR_NUM_SLOTS; s++) begin
            if (addr == RTAR_OFS_PHYS[s]) begin
               phys_reg[s] <= wdata[RTAR_ADDR_MSB:RTAR_ADDR_LSB];
            end
            if (addr == RTAR_OFS_ALIAS[s]) begin
               alias_reg[s] <= wdata[RTAR_ADDR_MSB:RTAR_ADDR_LSB];
               ack_reg[s]   <= wdata[RTAR_AUTO_ACK_BIT];
            end
         end
      end
   end

   // readback, reserved bit and unmapped offsets read zero
   always_comb begin
      rdata = 8'h00;
      for (int s = 0; s < RTAR_NUM_SLOTS; s++) begin
         if (addr == RTAR_OFS_PHYS[s]) begin
            rdata = {phys_reg[s], 1'b0};
         end
         if (addr == RTAR_OFS_ALIAS[s]) begin
            rdata = {alias_reg[s], ack_reg[s]};
         end
      end
   end

   assign target_phys_addr  = phys_reg;
   assign target_alias_addr = alias_reg;
   assign auto_ack          = ack_reg;

endmodule

// [verif/rtar_ser_model.sv]
// serializer end of the control channel: answers each forward after a delay
// assumes fwd_valid is a one-cycle strobe on ref_clk; bench sets delay and answer
`timescale 1ns/1ps

module rtar_ser_model (
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic       fwd_valid,
   input  wire logic       reply_ack,
   input  wire logic [3:0] reply_dly,
   output logic            ser_ack_valid,
   output logic            ser_ack
);
   logic [3:0] cnt_reg;

   // count down, strobe the answer; the answer line toggles while idle
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cnt_reg       <= 4'h0;
         ser_ack_valid <= 1'b0;
         ser_ack       <= 1'b0;
      end else begin
         ser_ack_valid <= 1'b0;
         ser_ack       <= ~ser_ack;   // no stale value between answers
         if (fwd_valid) begin
            cnt_reg <= reply_dly;
         end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
            if (cnt_reg == 4'h1) begin
               ser_ack_valid <= 1'b1;
               ser_ack       <= reply_ack;
            end
         end
      end
   end
endmodule

// [verif/remote_i2c_alias_remap_test.sv]
// self-checking bench for the alias remapper with a serializer model
// assumes the design answers per its hand-over timing, one transaction at a time
`timescale 1ns/1ps

module remote_i2c_alias_remap_test;
   import rtar_pkg::*;
   logic       ref_clk   = 1'b0;
   logic       resetn    = 1'b0;
   logic       reg_wr    = 1'b0;
   logic       reg_rd    = 1'b0;
   logic [7:0] reg_addr  = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       txn_valid = 1'b0;
   logic [6:0] txn_addr  = 7'h00;
   logic       txn_read  = 1'b0;
   logic       reply_ack = 1'b0;
   logic [3:0] reply_dly = 4'h1;
   logic [7:0] reg_rdata;
   logic       ser_ack_valid, ser_ack, fwd_valid, fwd_read, host_ack_valid, host_ack;
   logic [1:0] fwd_port;
   logic [6:0] fwd_addr;
   int         bad_count   = 0;
   int         comparisons = 0;
   int         old_ali;
   int         phys [4][4];
   int         ali  [4][4];
   int         aack [4][4];

   always #5 ref_clk = ~ref_clk;

   rtar_remap i_dut (.ref_clk(ref_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .txn_valid(txn_valid), .txn_addr(txn_addr), .txn_read(txn_read),
      .ser_ack_valid(ser_ack_valid), .ser_ack(ser_ack), .fwd_valid(fwd_valid),
      .fwd_port(fwd_port), .fwd_addr(fwd_addr), .fwd_read(fwd_read),
      .host_ack_valid(host_ack_valid), .host_ack(host_ack));
   rtar_ser_model i_ser (.ref_clk(ref_clk), .resetn(resetn), .fwd_valid(fwd_valid),
      .reply_ack(reply_ack), .reply_dly(reply_dly), .ser_ack_valid(ser_ack_valid),
      .ser_ack(ser_ack));

   ////////////////////////////////////////////////////////////////////////////////////////
   // compare, close, register access
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // read; data is left on reg_rdata for the caller
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
   endtask

   // program one slot of one port and mirror it in the model
   task automatic prog(input int p, input int s, input logic [6:0] a, input logic [7:0] ph,
                       input logic aa);
      wr(RTAR_OFS_PORT_SEL, 8'(p));
      wr(RTAR_OFS_PHYS[s], ph);
      wr(RTAR_OFS_ALIAS[s], {a, aa});
      phys[p][s] = ph[7:1];
      ali[p][s]  = a;
      aack[p][s] = aa;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////
   // one transaction: model lookup, drive, watch forward and answer
   task automatic txn(input logic [6:0] a, input logic rd_n);
      int         idx;
      int         fc;
      bit         got;
      logic [7:0] r;
      logic       exp;
      idx = -1;
      fc  = 0;
      got = 1'b0;
      r   = 8'($urandom);
      for (int p = 3; p >= 0; p--) begin
         for (int s = 3; s >= 0; s--) begin
            if (ali[p][s] != 0 && ali[p][s] == a) idx = p * 4 + s;
         end
      end
      exp = (idx < 0) ? 1'b0 : ((aack[idx/4][idx%4] != 0 && !rd_n) ? 1'b1 : r[0]);
      @(posedge ref_clk);
      txn_valid <= 1'b1;
      txn_addr  <= a;
      txn_read  <= rd_n;
      reply_ack <= r[0];
      reply_dly <= 4'($urandom_range(1, 6));
      @(posedge ref_clk);
      txn_valid <= 1'b0;
      for (int n = 0; n < 20 && !got; n++) begin
         @(negedge ref_clk);
         if (fwd_valid === 1'b1) begin
            fc++;
            chk({6'h00, fwd_port}, 8'(idx / 4));
            chk({1'b0, fwd_addr}, 8'(phys[idx/4][idx%4]));
            chk({7'h00, fwd_read}, {7'h00, rd_n});
         end
         if (host_ack_valid === 1'b1) begin
            got = 1'b1;
            chk({7'h00, host_ack}, {7'h00, exp});
         end
      end
      if (!got) begin
         bad_count++;
         stop_test();
      end
      chk(8'(fc), 8'(idx >= 0));
      // late serializer answers must not reach the controller
      repeat (12) begin
         @(negedge ref_clk);
         chk({7'h00, host_ack_valid}, 8'h00);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      void'($urandom(42948));
      repeat (10) @(posedge ref_clk);
      resetn <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         rd(RTAR_OFS_PHYS[s]);
         chk(reg_rdata, 8'h00);
         rd(RTAR_OFS_ALIAS[s]);
         chk(reg_rdata, 8'h00);
      end
      wr(8'h70, 8'h5a);
      rd(8'h70);
      chk(reg_rdata, 8'h00);
      for (int p = 0; p < 4; p++) begin
         for (int s = 0; s < 4; s++) prog(p, s, 7'($urandom_range(1, 127)), 8'($urandom), 1'b0);
      end
      // every port keeps its own copy
      for (int p = 0; p < 4; p++) begin
         wr(RTAR_OFS_PORT_SEL, 8'(p));
         rd(RTAR_OFS_PORT_SEL);
         chk(reg_rdata, 8'(p));
         for (int s = 0; s < 4; s++) begin
            rd(RTAR_OFS_PHYS[s]);
            chk(reg_rdata, 8'(phys[p][s] * 2));
            rd(RTAR_OFS_ALIAS[s]);
            chk(reg_rdata, 8'(ali[p][s] * 2));
         end
      end
      // remap on every slot, then random addresses
      for (int i = 0; i < 16; i++) txn(7'(ali[i/4][i%4]), 1'($urandom));
      repeat (6) txn(7'($urandom), 1'($urandom));
      // disabled slot stops matching, its old alias included
      old_ali = ali[1][0];
      prog(1, 0, 7'h00, 8'($urandom), 1'b0);
      txn(7'h00, 1'b0);
      txn(7'(old_ali), 1'b0);
      // auto-acknowledge on every slot of port 3, writes then reads
      for (int s = 0; s < 4; s++) begin
         prog(3, s, 7'(ali[3][s]), 8'(phys[3][s] * 2), 1'b1);
         txn(7'(ali[3][s]), 1'b0);
         txn(7'(ali[3][s]), 1'b1);
      end
      // second reset clears alias zero again
      @(posedge ref_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(RTAR_OFS_ALIAS[0]);
      chk(reg_rdata, 8'h00);
      for (int s = 1; s < 3; s++) begin
         rd(RTAR_OFS_PHYS[s]);
         chk(reg_rdata, 8'h00);
      end
      stop_test();
   end
endmodule
